// ==== design/ssnode_top.sv ====
// One node of the daisy-chained safety stop/reset network.
`timescale 1ns/1ps
// Summary of operation
// - An asserted local stop drives the chain output low to send STOP downstream.
// - STOP received on the chain input switches the local output off and is passed on.
// - A stop at any node spreads until every chain output in the network rests low.
// - With the stop released, one reset at the node that caused the stop sends START and restarts all nodes when network reset is on.
// - With network reset off, START arriving on the chain is ignored and only the local reset restarts the node.
// - After a network restart every output is back within about four seconds.
// - A low local enable drops the local output while RUN keeps going out on the chain.
// - After an enable-caused stop the node needs a local reset and flashes its reset indicator.
// - Without global reset, a node stopped by its enable restarts only from its own reset input.
// - The local output is high only while the enable is high and the node has been restarted.
// - With stop-cause reporting on, network and local stop flags rise on their cause and hold until reset.
// - With error output on, the error output is high while a failure is present.
module ssnode_top #(
   parameter longint RESTORE_CYC = ssnode_pkg::RESTORE_CYC_L,
   parameter int START_HALF = ssnode_pkg::START_HALF_CYC,
   parameter int STEADY = ssnode_pkg::STEADY_CYC,
   parameter int FLASH = ssnode_pkg::FLASH_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic chain_in,
   input wire logic stop_in,
   input wire logic reset_in,
   input wire logic local_enable,
   input wire logic net_reset_en,
   input wire logic global_reset_en,
   input wire logic stop_cause_en,
   input wire logic error_out_en,
   input wire logic failure,
   output logic chain_out,
   output logic local_out,
   output logic net_stop_flag,
   output logic local_stop_flag,
   output logic error_out,
   output logic reset_led,
   output logic restore_busy
);
   typedef enum logic [1:0] {ST_STOP, ST_START, ST_RUN} ssnode_state_t;

   ssnode_state_t state_r;
   logic rx_stop;
   logic rx_run;
   logic rx_start;
   logic reset_prev_r;
   logic reset_rise;
   logic [7:0] burst_r;
   logic [15:0] half_r;
   logic tone_r;
   logic enable_lock_r;
   logic stop_origin_r;
   logic [39:0] restore_r;
   logic [31:0] flash_r;
   logic flash_bit_r;
   logic restart_ok;
   logic net_restart;

   // ---------------------------------------------------------------
   // Chain input decoder
   // ---------------------------------------------------------------
   ssnode_chain_rx #(
      .STEADY(STEADY),
      .MIN_EDGES(ssnode_pkg::START_MIN_EDGES)
   ) u_rx (
      .mclk(mclk),
      .rst(rst),
      .line_in(chain_in),
      .is_stop(rx_stop),
      .is_run(rx_run),
      .is_start(rx_start)
   );

   // Local reset is taken on its rising edge, so a held button cannot retrigger.
   assign reset_rise = reset_in && !reset_prev_r;
   // A chain START counts only when network reset is enabled.
   assign net_restart = rx_start && net_reset_en;
   // The node that caused the stop, or one held by its enable, needs its own reset unless global reset is on.
   assign restart_ok = !stop_in && (reset_rise ||
                       (net_restart && !((stop_origin_r || enable_lock_r) && !global_reset_en)));

   always_ff @(posedge mclk) begin
      if (rst) begin
         reset_prev_r <= 1'b0;
      end else begin
         reset_prev_r <= reset_in;
      end
   end

   // ---------------------------------------------------------------
   // Node state machine
   // ---------------------------------------------------------------
   // The local stop wins in every state; a restart first sends a START burst, then RUN.
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= ST_STOP;
      end else if (stop_in) begin
         state_r <= ST_STOP;
      end else begin
         case (state_r)
            ST_STOP: begin
               if (restart_ok) begin
                  state_r <= ST_START;
               end
            end
            ST_START: begin
               if (burst_r == 8'(ssnode_pkg::START_HALVES)) begin
                  state_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (rx_stop) begin
                  state_r <= ST_STOP;
               end
            end
            default: begin
               state_r <= ST_STOP;
            end
         endcase
      end
   end

   // Remember whether this node originated the stop.
   always_ff @(posedge mclk) begin
      if (rst) begin
         stop_origin_r <= 1'b0;
      end else if (stop_in) begin
         stop_origin_r <= 1'b1;
      end else if (state_r == ST_STOP && restart_ok) begin
         // Any accepted restart ends the origin mark, so a later network START is not refused by a stale flag.
         stop_origin_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // START tone generator
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst || state_r != ST_START) begin
         half_r <= 16'h0000;
         burst_r <= 8'h00;
         tone_r <= 1'b1;
      end else if (half_r == 16'(START_HALF - 1)) begin
         half_r <= 16'h0000;
         burst_r <= burst_r + 8'h01;
         tone_r <= !tone_r;
      end else begin
         half_r <= half_r + 16'h0001;
      end
   end

   // Chain output: low in STOP, tone in START, high in RUN until STOP is seen on the chain input.
   always_ff @(posedge mclk) begin
      if (rst) begin
         chain_out <= ssnode_pkg::CHAIN_OUT_RST;
      end else begin
         case (state_r)
            ST_START: chain_out <= tone_r && !stop_in;
            ST_RUN: chain_out <= !stop_in && !rx_stop;
            default: chain_out <= 1'b0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Local enable lock and local output
   // ---------------------------------------------------------------
   // A drop of the enable latches a lock that a local reset clears, or a network restart when global reset is on.
   always_ff @(posedge mclk) begin
      if (rst) begin
         enable_lock_r <= 1'b0;
      end else if (state_r == ST_RUN && !local_enable) begin
         enable_lock_r <= 1'b1;
      end else if (local_enable && ((reset_rise && !stop_in) || (state_r == ST_STOP && restart_ok))) begin
         // A network restart is only accepted for a locked node when global reset is on, so it may clear the lock.
         enable_lock_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         local_out <= ssnode_pkg::RUN_RST;
      end else begin
         local_out <= (state_r == ST_RUN) && local_enable && !enable_lock_r && !stop_in;
      end
   end

   // ---------------------------------------------------------------
   // Stop cause flags and error output
   // ---------------------------------------------------------------
   // Set beats clear: a new cause in the reset cycle keeps the flag raised.
   always_ff @(posedge mclk) begin
      if (rst) begin
         net_stop_flag <= 1'b0;
         local_stop_flag <= 1'b0;
      end else begin
         if (stop_cause_en && state_r == ST_RUN && rx_stop && !stop_in) begin
            net_stop_flag <= 1'b1;
         end else if (reset_rise || !stop_cause_en) begin
            net_stop_flag <= 1'b0;
         end
         if (stop_cause_en && state_r == ST_RUN && (stop_in || !local_enable)) begin
            local_stop_flag <= 1'b1;
         end else if (reset_rise || !stop_cause_en) begin
            local_stop_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         error_out <= 1'b0;
      end else begin
         error_out <= error_out_en && failure;
      end
   end

   // ---------------------------------------------------------------
   // Restore window and reset indicator
   // ---------------------------------------------------------------
   // The busy flag is high from a restart until this node reaches RUN or the restore window ends.
   always_ff @(posedge mclk) begin
      if (rst) begin
         restore_r <= 40'h00_0000_0000;
         restore_busy <= 1'b0;
      end else if (state_r == ST_STOP && restart_ok) begin
         restore_r <= 40'(RESTORE_CYC);
         restore_busy <= 1'b1;
      end else if (restore_r != 40'h00_0000_0000) begin
         restore_r <= restore_r - 40'h00_0000_0001;
         restore_busy <= (restore_r != 40'h00_0000_0001) && (state_r != ST_RUN);
      end else begin
         restore_busy <= 1'b0;
      end
   end

   // The reset LED flashes while a local reset is needed, and is steady on in RUN.
   always_ff @(posedge mclk) begin
      if (rst) begin
         flash_r <= 32'h0000_0000;
         flash_bit_r <= 1'b0;
         reset_led <= 1'b0;
      end else begin
         if (flash_r == 32'(FLASH - 1)) begin
            flash_r <= 32'h0000_0000;
            flash_bit_r <= !flash_bit_r;
         end else begin
            flash_r <= flash_r + 32'h0000_0001;
         end
         if (enable_lock_r || (state_r == ST_STOP && !stop_in)) begin
            reset_led <= flash_bit_r;
         end else begin
            reset_led <= (state_r == ST_RUN);
         end
      end
   end
endmodule

// ==== pkg/ssnode_pkg.sv ====
// Shared constants for the safety stop/reset network node.
package ssnode_pkg;
   // -------------------------------------------------------------------------
   // Chain line signalling
   // -------------------------------------------------------------------------
   // The chain line is a single wire. STOP is a steady low, RUN is a steady
   // high, and START is a square wave of fixed half period, so a receiver can
   // tell all three apart by watching for edges over a short window.
   localparam int CLK_HZ = 40_000_000;
   localparam int START_HALF_US = 10;
   localparam int START_HALF_CYC = (START_HALF_US * (CLK_HZ / 1_000_000));
   // Number of START half periods sent per restart.
   localparam int START_HALVES = 16;
   // A line is called steady once it has not toggled for this many cycles.
   localparam int STEADY_CYC = 4 * START_HALF_CYC;
   // Toggles seen within a steady window that qualify as START.
   localparam int START_MIN_EDGES = 3;
   // Network restore time: all outputs restored within about four seconds.
   localparam int RESTORE_MS = 4000;
   localparam longint RESTORE_CYC_L = (longint'(RESTORE_MS) * longint'(CLK_HZ)) / 1000;
   // Half period of the reset indicator flash, in cycles.
   localparam int FLASH_MS = 250;
   localparam int FLASH_CYC = (FLASH_MS * (CLK_HZ / 1000));
   // Reset values.
   localparam logic CHAIN_OUT_RST = 1'b0;
   localparam logic RUN_RST = 1'b0;
endpackage

// ==== design/ssnode_chain_rx.sv ====
// Chain line decoder that classifies the incoming line as STOP, START or RUN.
`timescale 1ns/1ps
module ssnode_chain_rx #(
   parameter int STEADY = ssnode_pkg::STEADY_CYC,
   parameter int MIN_EDGES = ssnode_pkg::START_MIN_EDGES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic line_in,
   output logic is_stop,
   output logic is_run,
   output logic is_start
);
   logic prev_r;
   logic [15:0] quiet_r;
   logic [7:0] edges_r;

   // ---------------------------------------------------------------
   // Edge watch
   // ---------------------------------------------------------------
   // Count edges and quiet time; a long quiet spell means the line is steady.
   always_ff @(posedge mclk) begin
      if (rst) begin
         prev_r <= 1'b0;
         quiet_r <= 16'h0000;
         edges_r <= 8'h00;
      end else begin
         prev_r <= line_in;
         if (line_in != prev_r) begin
            quiet_r <= 16'h0000;
            if (edges_r != 8'hFF) begin
               edges_r <= edges_r + 8'h01;
            end
         end else if (quiet_r < 16'(STEADY)) begin
            quiet_r <= quiet_r + 16'h0001;
         end else begin
            edges_r <= 8'h00; // Burst has ended.
         end
      end
   end

   // ---------------------------------------------------------------
   // Classification
   // ---------------------------------------------------------------
   // Level decisions wait for a steady line so that START never looks like RUN.
   always_ff @(posedge mclk) begin
      if (rst) begin
         is_stop <= 1'b1;
         is_run <= 1'b0;
         is_start <= 1'b0;
      end else begin
         is_start <= (edges_r >= 8'(MIN_EDGES));
         is_stop <= (quiet_r >= 16'(STEADY)) && !prev_r;
         is_run <= (quiet_r >= 16'(STEADY)) && prev_r;
      end
   end
endmodule

// ==== test/ssnode_monitor.sv ====
// Assertion checker watching the ports of one safety network node.
`timescale 1ns/1ps
module ssnode_monitor #(
   parameter longint RESTORE_CYC = 200,
   parameter int STEADY = 16
) (
   input wire logic mclk, rst, chain_in, stop_in, reset_in, local_enable,
   input wire logic net_reset_en, global_reset_en, stop_cause_en, error_out_en, failure,
   input wire logic chain_out, local_out, net_stop_flag, local_stop_flag, error_out,
   input wire logic reset_led, restore_busy
);
   int low_cnt;
   int busy_cnt;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Length of the current quiet-low stretch on the chain input.
   always_ff @(posedge mclk) begin
      low_cnt <= (rst || chain_in) ? 0 : low_cnt + 1;
   end
   // Length of the busy stretch; a counter avoids a huge unrolled repetition.
   always_ff @(posedge mclk) begin
      busy_cnt <= (rst || !restore_busy) ? 0 : busy_cnt + 1;
   end
   chk_stop_drops_chain: assert property (stop_in |=> !chain_out && !local_out)
      else $error("chain or output stayed on under local stop");
   chk_chain_stop_spreads: assert property (low_cnt == STEADY + 4 |-> !chain_out && !local_out)
      else $error("steady stop on chain input not passed on");
   chk_start_tone: assert property ($rose(reset_in) && !stop_in && !chain_out |-> ##[1:3] chain_out)
      else $error("local reset did not start the tone");
   chk_enable_keeps_run: assert property ($fell(local_enable) && chain_out && !restore_busy && chain_in
      |=> chain_out [*4]) else $error("enable drop disturbed the chain");
   chk_output_gate: assert property (!local_enable || stop_in |=> !local_out)
      else $error("output on without enable");
   chk_led_flash: assert property ($fell(local_enable) && local_out |-> ##[1:20] !reset_led)
      else $error("reset indicator did not flash");
   chk_error_level: assert property (error_out_en && failure |=> error_out)
      else $error("error output missing");
   chk_local_flag: assert property (stop_cause_en && stop_in && local_out |-> ##[1:3] local_stop_flag)
      else $error("local stop flag missing");
   chk_flags_off: assert property (!stop_cause_en [*2] |-> !net_stop_flag && !local_stop_flag)
      else $error("stop flags set while reporting off");
   chk_restore_bound: assert property (longint'(busy_cnt) <= RESTORE_CYC + 1)
      else $error("restore span overran");
   cover property ($rose(reset_in) && !stop_in ##[1:3] chain_out);
   cover property ($fell(local_enable) && local_out);
   cover property ($fell(restore_busy) && local_out);
endmodule

// ==== test/ssnode_neighbour.sv ====
// Upstream neighbour node model driving the chain line.
`timescale 1ns/1ps
module ssnode_neighbour #(
   parameter int HALF = 4
) (
   input wire logic mclk,
   input wire logic [1:0] mode,
   output logic line
);
   int cnt = 0;
   int halves = 0;
   initial line = 1'h0;
   // Mode 0 holds STOP, 1 holds RUN, 2 sends one START burst then RUN.
   always @(negedge mclk) begin
      if (mode != 2'h2) begin
         line <= mode[0];
         halves <= 0;
         cnt <= 0;
      end else if (halves < ssnode_pkg::START_HALVES) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) begin
            line <= !line;
            halves <= halves + 1;
         end
      end else begin
         line <= 1'h1;
      end
   end
endmodule

// ==== test/ssnode_top_bench.sv ====
// Self-checking bench for one node between an upstream model and its pins.
`timescale 1ns/1ps
module ssnode_top_bench;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic stop_in = 1'h0, reset_in = 1'h0, local_enable = 1'h1, net_reset_en = 1'h1;
   logic global_reset_en = 1'h0, stop_cause_en = 1'h1, error_out_en = 1'h1, failure = 1'h0;
   logic chain_in, chain_out, local_out, net_stop_flag, local_stop_flag, error_out, reset_led, restore_busy;
   logic [1:0] mode = 2'h0;
   int failures = 0;
   int checks_done = 0;
   int e;
   ssnode_top #(.RESTORE_CYC(200), .START_HALF(4), .STEADY(16), .FLASH(8)) DUT (.mclk(mclk), .rst(rst),
      .chain_in(chain_in), .stop_in(stop_in), .reset_in(reset_in), .local_enable(local_enable),
      .net_reset_en(net_reset_en), .global_reset_en(global_reset_en), .stop_cause_en(stop_cause_en),
      .error_out_en(error_out_en), .failure(failure), .chain_out(chain_out), .local_out(local_out),
      .net_stop_flag(net_stop_flag), .local_stop_flag(local_stop_flag), .error_out(error_out),
      .reset_led(reset_led), .restore_busy(restore_busy));
   ssnode_neighbour #(.HALF(4)) up (.mclk(mclk), .mode(mode), .line(chain_in));
   initial forever #12.5 mclk = ~mclk;
   task automatic check(input string what, input logic seen, input logic exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   // Button press held for three cycles, released at a falling edge.
   task automatic press;
      reset_in = 1'h1;
      tick(3);
      reset_in = 1'h0;
   endtask
   // Counts changes of the chain output or of the indicator over n cycles.
   task automatic toggles(input int n, input logic led, output int cnt);
      logic last;
      cnt = 0;
      last = led ? reset_led : chain_out;
      repeat (n) begin
         @(negedge mclk);
         if ((led ? reset_led : chain_out) !== last) cnt++;
         last = led ? reset_led : chain_out;
      end
   endtask
   task automatic give_verdict;
      if (failures == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // A hang is cut short well after the roughly 1800 cycles the tests need.
   initial begin
      repeat (6000) @(posedge mclk);
      failures++;
      give_verdict();
   end
   initial begin
      repeat (16) @(negedge mclk);
      rst = 1'h0;
      tick(20);
      check("chain_out", chain_out, 1'h0);
      check("local_out", local_out, 1'h0);
      mode = 2'h1;
      tick(20);
      press();
      toggles(60, 1'h0, e);
      check("start tone", e >= 3, 1'h1);
      tick(40);
      check("chain_out", chain_out, 1'h1);
      check("local_out", local_out, 1'h1);
      // Enable drop keeps RUN on the chain but needs a local reset afterwards.
      local_enable = 1'h0;
      toggles(30, 1'h1, e);
      check("led flash", e >= 2, 1'h1);
      check("local_out", local_out, 1'h0);
      check("chain_out", chain_out, 1'h1);
      check("local flag", local_stop_flag, 1'h1);
      local_enable = 1'h1;
      tick(10);
      check("local_out", local_out, 1'h0);
      press();
      tick(90);
      check("local_out", local_out, 1'h1);
      check("local flag", local_stop_flag, 1'h0);
      // A restart is refused while the local stop is still held.
      stop_in = 1'h1;
      tick(2);
      check("chain_out", chain_out, 1'h0);
      press();
      tick(10);
      check("chain_out", chain_out, 1'h0);
      stop_in = 1'h0;
      press();
      tick(90);
      check("chain_out", chain_out, 1'h1);
      // Upstream stop spreads, then a network START restarts this node.
      mode = 2'h0;
      tick(30);
      check("chain_out", chain_out, 1'h0);
      check("local_out", local_out, 1'h0);
      check("net flag", net_stop_flag, 1'h1);
      mode = 2'h2;
      tick(30);
      check("restore_busy", restore_busy, 1'h1);
      tick(220);
      check("local_out", local_out, 1'h1);
      check("restore_busy", restore_busy, 1'h0);
      // Network START is ignored when network reset is off.
      net_reset_en = 1'h0;
      mode = 2'h0;
      tick(30);
      mode = 2'h2;
      tick(250);
      check("chain_out", chain_out, 1'h0);
      press();
      tick(90);
      check("chain_out", chain_out, 1'h1);
      net_reset_en = 1'h1;
      // An enable-locked node takes a network START only with global reset.
      for (int g = 0; g < 2; g++) begin
         global_reset_en = g[0];
         local_enable = 1'h0;
         tick(5);
         local_enable = 1'h1;
         mode = 2'h0;
         tick(30);
         mode = 2'h2;
         tick(250);
         check("locked out", local_out, g[0]);
         press();
         tick(90);
      end
      for (int i = 0; i < 2; i++) begin
         error_out_en = i[0];
         failure = 1'h1;
         tick(3);
         check("error_out", error_out, i[0]);
      end
      stop_cause_en = 1'h0;
      tick(3);
      check("local flag", local_stop_flag, 1'h0);
      give_verdict();
   end
endmodule
bind ssnode_top ssnode_monitor #(.RESTORE_CYC(RESTORE_CYC), .STEADY(STEADY)) mon (.mclk(mclk), .rst(rst),
   .chain_in(chain_in), .stop_in(stop_in), .reset_in(reset_in), .local_enable(local_enable),
   .net_reset_en(net_reset_en), .global_reset_en(global_reset_en), .stop_cause_en(stop_cause_en),
   .error_out_en(error_out_en), .failure(failure), .chain_out(chain_out), .local_out(local_out),
   .net_stop_flag(net_stop_flag), .local_stop_flag(local_stop_flag), .error_out(error_out),
   .reset_led(reset_led), .restore_busy(restore_busy));
